// File: rtl/ocl_lister.sv
// Ordered channel lister: ranks comparator winners into a seven-entry list.
// Assumes winner lines arrive asynchronously from the comparator and that the
// decoder accepts each valid address in the cycle it is shown.
`timescale 1ns/1ps
module ocl_lister #(
	parameter int SETTLE = ocl_pkg::SETTLE_CYCLES,
	parameter int BURST  = ocl_pkg::BURST_CYCLES,
	parameter int SLOW   = ocl_pkg::SLOW_CYCLES
) (
	input  wire logic                                  i_clock,
	input  wire logic                                  i_sys_rst,
	input  wire logic [1:0]                            i_rate_mode,
	input  wire logic [ocl_pkg::NUM_CHANNELS-1:0]      i_winner,
	output logic      [ocl_pkg::NUM_CHANNELS-1:0]      o_inhibit,
	output logic                                       o_sample,
	output logic                                       o_valid,
	output ocl_pkg::ocl_entry_s                        o_entry,
	output logic                                       o_list_done
);

	localparam int N  = ocl_pkg::NUM_CHANNELS;
	localparam int AW = ocl_pkg::ADDR_WIDTH;
	localparam int L  = ocl_pkg::LIST_LENGTH;

	// Step timing points within the settle count.
	// The two sync stages add two cycles, so capturing at SETTLE+1 means
	// the winner read here left the comparator a full SETTLE cycles after
	// the mask last moved. Capturing one cycle sooner would short the
	// comparator's response time by a cycle.
	localparam int CAPTURE_AT = SETTLE + 1;
	localparam int TAKE_AT    = SETTLE + 2;

	typedef enum logic [1:0] {
		OCL_IDLE,
		OCL_SETTLE,
		OCL_TAKE
	} ocl_state_e;

	ocl_state_e state_q;
	logic [N-1:0]  win_meta_q;
	logic [N-1:0]  win_sync_q;
	logic [N-1:0]  capture_q;
	logic [N-1:0]  inhibit_q;
	logic [31:0]   frame_cnt_q;
	logic [31:0]   settle_cnt_q;
	logic [2:0]    index_q;
	logic          start;
	logic          last_entry;
	logic [N-1:0]  grant_a;
	logic [N-1:0]  grant_b;
	logic [AW-1:0] addr_a;
	logic [AW-1:0] addr_b;
	logic          none_a;
	logic          mode_slow;

	// ****************************************
	// Winner line synchroniser
	// ****************************************
	// Two stages; only the second is read by logic
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			win_meta_q <= '0;
			win_sync_q <= '0;
		end else begin
			win_meta_q <= i_winner;
			win_sync_q <= win_meta_q;
		end
	end

	// ****************************************
	// List start timing
	// ****************************************
	assign mode_slow = (i_rate_mode == 2'(ocl_pkg::OCL_RATE_200));

	// Interval divider makes the sampling strobe
	// one list per interval
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			frame_cnt_q <= '0;
		end else if (start) begin
			frame_cnt_q <= '0;
		end else begin
			frame_cnt_q <= frame_cnt_q + 32'd1;
		end
	end
	assign start = mode_slow ? (frame_cnt_q >= 32'(SLOW - 1)) : (frame_cnt_q >= 32'(BURST - 1));
	assign o_sample = start;

	// ****************************************
	// Step sequencer
	// ****************************************
	assign last_entry = (index_q == 3'(L - 1));

	// A start mid-list restarts; the old list is abandoned, not merged
	// start strobe and settled steps
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q      <= OCL_IDLE;
			settle_cnt_q <= '0;
			index_q      <= '0;
		end else if (start) begin
			state_q      <= OCL_SETTLE;
			settle_cnt_q <= '0;
			index_q      <= '0;
		end else begin
			case (state_q)
				OCL_IDLE: begin
					state_q <= OCL_IDLE;
				end
				OCL_SETTLE: begin
					if (settle_cnt_q >= 32'(TAKE_AT)) begin
						state_q <= OCL_TAKE;
					end else begin
						settle_cnt_q <= settle_cnt_q + 32'd1;
					end
				end
				OCL_TAKE: begin
					settle_cnt_q <= '0;
					if (last_entry) begin
						state_q <= OCL_IDLE;
						index_q <= '0;
					end else begin
						state_q <= OCL_SETTLE;
						index_q <= index_q + 3'd1;
					end
				end
				default: begin
					state_q <= OCL_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Capture flags
	// ****************************************
	// Flags load the settled winner, masked by inhibit; old flags drop
	// Mask is steady from capture to take, so flag and grant agree
	// capture new winner
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			capture_q <= '0;
		end else if (state_q == OCL_SETTLE && settle_cnt_q == 32'(CAPTURE_AT)) begin
			capture_q <= win_sync_q & ~inhibit_q;
		end
	end

	// ****************************************
	// Selection chains
	// ****************************************
	// lowest flag wins, encoded
	ocl_pick #(.N(N), .AW(AW)) u_first (
		.i_req   (capture_q),
		.o_grant (grant_a),
		.o_addr  (addr_a),
		.o_none  (none_a)
	);

	ocl_pick #(.N(N), .AW(AW)) u_second (
		.i_req   (~inhibit_q),
		.o_grant (grant_b),
		.o_addr  (addr_b),
		.o_none  ()
	);

	// ****************************************
	// Inhibit mask
	// ****************************************
	// accumulate, clear per list
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			inhibit_q <= '0;
		end else if (start) begin
			inhibit_q <= '0;
		end else if (state_q == OCL_TAKE) begin
			if (last_entry) begin
				inhibit_q <= '0;
			end else begin
				inhibit_q <= inhibit_q | (none_a ? grant_b : grant_a);
			end
		end
	end
	assign o_inhibit = inhibit_q;

	// ****************************************
	// Output to decoder
	// ****************************************
	// Entry register loads only on a take, so the decoder may read the
	// address and last flag at any time until the next take, including a take cut by a start, which shows no valid pulse.
	// A start that cuts a step drops its valid and done pulses.
	// one registered entry per step
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_valid       <= 1'b0;
			o_entry       <= '0;
			o_list_done   <= 1'b0;
		end else begin
			o_valid     <= (state_q == OCL_TAKE) && !start;
			o_list_done <= (state_q == OCL_TAKE) && !start && last_entry;
			if (state_q == OCL_TAKE) begin
				o_entry.addr <= none_a ? addr_b : addr_a;
				o_entry.last <= last_entry;
			end
		end
	end

endmodule : ocl_lister

// File: rtl/ocl_pkg.sv
// Package for the ordered channel lister: sizes, modes, timing constants.
// Assumes a single 40 MHz clock shared by every user of these constants.
package ocl_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CHANNELS  = 16;
	localparam int ADDR_WIDTH    = 4;
	localparam int LIST_LENGTH   = 7;
	localparam int REPEAT_SYMS   = 24;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_MHZ        = 40;
	localparam int SETTLE_US        = 5;
	localparam int SETTLE_CYCLES    = SETTLE_US * CLOCK_MHZ;
	localparam int BURST_US         = 200;
	localparam int BURST_CYCLES     = BURST_US * CLOCK_MHZ;
	localparam int SLOW_PERIOD_MS   = 5;
	localparam int SLOW_CYCLES      = SLOW_PERIOD_MS * 1000 * CLOCK_MHZ;

	// ****************************************
	// Data-rate modes
	// ****************************************
	typedef enum logic [1:0] {
		OCL_RATE_10K,
		OCL_RATE_5K,
		OCL_RATE_200
	} ocl_rate_e;

	// One list entry towards the decoder
	typedef struct packed {
		logic                  last;
		logic [ADDR_WIDTH-1:0] addr;
	} ocl_entry_s;

endpackage : ocl_pkg

// File: rtl/ocl_pick.sv
// One-hot priority picker with a no-selection flag.
// Assumes the request vector is registered in the caller's clock domain.
`timescale 1ns/1ps
module ocl_pick #(
	parameter int N  = 16,
	parameter int AW = 4
) (
	input  wire logic [N-1:0]  i_req,
	output logic      [N-1:0]  o_grant,
	output logic      [AW-1:0] o_addr,
	output logic               o_none
);

	// ****************************************
	// Priority chain
	// ****************************************
	// Carry runs down the chain; the first set bit blocks later ones
	logic [N:0] seen;
	assign seen[0] = 1'b0;
	generate
		for (genvar g = 0; g < N; g++) begin : g_chain
			assign o_grant[g]  = i_req[g] & ~seen[g];
			assign seen[g + 1] = seen[g] | i_req[g];
		end
	endgenerate
	// End of chain tells that nothing was requested
	assign o_none = ~seen[N];

	// One-hot to binary encode
	always_comb begin
		o_addr = '0;
		for (int k = 0; k < N; k++) begin
			if (o_grant[k]) begin
				o_addr = AW'(k);
			end
		end
	end

endmodule : ocl_pick

// File: tb/ocl_lister_assertions.sv
// Checker for the ordered channel lister, bound to its ports.
// Assumes the short timing parameters handed on by the bind.
`timescale 1ns/1ps
module ocl_lister_assertions #(
	parameter int SETTLE = 4,
	parameter int BURST  = 80,
	parameter int SLOW   = 400
) (
	input wire logic                i_clock,
	input wire logic                i_sys_rst,
	input wire logic [1:0]          i_rate_mode,
	input wire logic [15:0]         i_winner,
	input wire logic [15:0]         o_inhibit,
	input wire logic                o_sample,
	input wire logic                o_valid,
	input wire ocl_pkg::ocl_entry_s o_entry,
	input wire logic                o_list_done
);
	localparam int FIRST = SETTLE + 5;
	localparam int STEP  = SETTLE + 4;
	int cnt_q;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// Cycles since list start; negative until the first start, which is untimed
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) cnt_q <= -(1 << 20);
		else cnt_q <= o_sample ? 0 : cnt_q + 1;
	end
	property p_inh0; o_sample |=> o_inhibit == 16'h0; endproperty
	a_inh0: assert property (p_inh0) else $error("mask set at start");
	property p_first; o_sample |-> ##FIRST o_valid; endproperty
	a_first: assert property (p_first) else $error("first entry late");
	property p_gap; o_valid && !o_entry.last |-> ##STEP o_valid; endproperty
	a_gap: assert property (p_gap) else $error("entry spacing");
	property p_accept; o_valid && !o_entry.last |-> o_inhibit[o_entry.addr]; endproperty
	a_accept: assert property (p_accept) else $error("entry not masked");
	// Bits only fall when the whole mask clears
	property p_accum; 1 |=> ((o_inhibit & $past(o_inhibit)) == $past(o_inhibit)) || o_inhibit == 16'h0; endproperty
	a_accum: assert property (p_accum) else $error("mask lost a bit");
	property p_clear; o_list_done |=> o_inhibit == 16'h0; endproperty
	a_clear: assert property (p_clear) else $error("mask kept after list");
	property p_pair; 1 |-> (o_valid && o_entry.last) == o_list_done; endproperty
	a_pair: assert property (p_pair) else $error("done not with last");
	property p_period; o_sample && cnt_q >= 0 |-> cnt_q == ((i_rate_mode == 2'h2) ? SLOW : BURST) - 1; endproperty
	a_period: assert property (p_period) else $error("list period");
	c_done: cover property (o_list_done);
	c_slow: cover property (o_sample && i_rate_mode == 2'h2 && cnt_q >= 0);
	c_blank: cover property (o_valid && i_winner == 16'h0);
	c_tie: cover property ($countones(i_winner) > 1);
endmodule : ocl_lister_assertions

bind ocl_lister ocl_lister_assertions #(.SETTLE(SETTLE), .BURST(BURST), .SLOW(SLOW)) chk (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_rate_mode(i_rate_mode), .i_winner(i_winner),
	.o_inhibit(o_inhibit), .o_sample(o_sample), .o_valid(o_valid), .o_entry(o_entry), .o_list_done(o_list_done));

// File: tb/ocl_comparator_model.sv
// Comparator model: raises the line of the strongest unmasked channel.
// Equal peaks raise every tied line, standing in for indecision; mute holds all low.
`timescale 1ns/1ps
module ocl_comparator_model (
	input  wire logic [15:0][7:0] i_amp,
	input  wire logic [15:0]      i_inhibit,
	input  wire logic             i_mute,
	output logic      [15:0]      o_winner
);
	int best;
	always_comb begin
		best = -1;
		for (int c = 0; c < 16; c++)
			if (!i_inhibit[c] && (best < 0 || i_amp[c] > i_amp[best])) best = c;
		o_winner = 16'h0;
		for (int c = 0; c < 16; c++)
			if (best >= 0 && !i_mute && !i_inhibit[c] && i_amp[c] == i_amp[best]) o_winner[c] = 1'h1;
	end
endmodule : ocl_comparator_model

// File: tb/ocl_lister_tb.sv
// Testbench for the ordered channel lister; the bench acts as decoder.
// Assumes short timing parameters so a slow list stays brief.
`timescale 1ns/1ps
module ocl_lister_tb;
	logic                i_clock, i_sys_rst, mute;
	logic [1:0]          i_rate_mode;
	logic [15:0][7:0]    amp;
	logic [15:0]         i_winner, o_inhibit;
	logic                o_sample, o_valid, o_list_done;
	ocl_pkg::ocl_entry_s o_entry;
	logic [4:0]          exp_q[$], exp_e;
	int                  error_cnt = 0, num_checks = 0;
	logic [1:0]          modes[5] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h2};
	ocl_lister #(.SETTLE(4), .BURST(80), .SLOW(400)) ocl_lister_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_rate_mode(i_rate_mode), .i_winner(i_winner), .o_inhibit(o_inhibit), .o_sample(o_sample),
		.o_valid(o_valid), .o_entry(o_entry), .o_list_done(o_list_done));
	ocl_comparator_model ocl_comparator_model_inst (.i_amp(amp), .i_inhibit(o_inhibit), .i_mute(mute),
		.o_winner(i_winner));
	// 40 MHz clock
	initial begin
		i_clock = 1'h0;
		forever #12.5 i_clock = ~i_clock;
	end
	task automatic report_and_stop;
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic bad(input logic [4:0] got, input logic [4:0] want);
		error_cnt++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, want);
	endtask : bad
	// Decoder side: oldest note against each entry shown, read mid-cycle
	always @(negedge i_clock) begin
		if (o_valid === 1'h1) begin
			num_checks++;
			if (exp_q.size() == 0) bad(o_entry, 5'h1F);
			else begin
				exp_e = exp_q.pop_front();
				if (o_entry !== exp_e) bad(o_entry, exp_e);
			end
		end
	end
	// Strongest untaken first; lowest untaken when the comparator is mute
	task automatic note_list;
		logic [15:0] taken;
		int best;
		taken = 16'h0;
		for (int k = 0; k < ocl_pkg::LIST_LENGTH; k++) begin
			best = -1;
			for (int c = 0; c < 16; c++)
				if (!taken[c] && (best < 0 || (!mute && amp[c] > amp[best]))) best = c;
			taken[best] = 1'h1;
			exp_q.push_back({k == ocl_pkg::LIST_LENGTH - 1, 4'(best)});
		end
	endtask : note_list
	// Bounded wait for the end of a list
	task automatic wait_done;
		for (int i = 0; i < 800; i++) begin
			@(posedge i_clock);
			#1;
			if (o_list_done === 1'h1) return;
		end
		bad(5'h0, 5'h1F);
		report_and_stop();
	endtask : wait_done
	// Lists over every rate code, one with a mute comparator
	initial begin
		logic [7:0] tmp;
		int j;
		i_sys_rst = 1'h1;
		i_rate_mode = 2'h0;
		mute = 1'h0;
		void'($urandom(32'h500EF8CA));
		for (int i = 0; i < 16; i++) amp[i] = 8'(i * 9 + 3);
		repeat (16) @(posedge i_clock);
		@(negedge i_clock);
		i_sys_rst = 1'h0;
		for (int t = 0; t < 5; t++) begin
			i_rate_mode = modes[t];
			mute = (t == 3);
			for (int i = 15; i > 0; i--) begin
				j = $urandom % (i + 1);
				tmp = amp[i];
				amp[i] = amp[j];
				amp[j] = tmp;
			end
			// Two equal peaks from here on make the comparator indecisive
			if (t == 2) begin
				amp[5] = 8'hFF;
				amp[11] = 8'hFF;
			end
			note_list();
			wait_done();
			@(negedge i_clock);
		end
		// Let the decoder side take the last entry first
		@(posedge i_clock);
		num_checks++;
		if (exp_q.size() != 0) bad(5'h0, exp_q[0]);
		report_and_stop();
	end
endmodule : ocl_lister_tb
